// file: memory_interface_dma.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module memory_interface_dma
  import mem_dma_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic i_core_req,
  input wire logic i_core_wr,
  input wire logic [1:0] i_core_space,
  input wire logic [13:0] i_core_addr,
  input wire logic [23:0] i_core_wdata,
  output logic o_core_done,
  output logic [23:0] o_core_rdata,
  output logic o_core_halt,
  output logic o_core_ctx_reset,
  output logic [13:0] o_ext_addr,
  input wire logic [23:0] i_ext_data,
  output logic [23:0] o_ext_data,
  output logic [2:0] o_ext_data_oe_n,
  output logic o_program_mem_select,
  output logic o_data_mem_select,
  output logic o_byte_mem_select,
  output logic o_io_space_select,
  output logic o_composite_select_out,
  output logic o_ext_rd,
  output logic o_ext_wr,
  output logic o_mem_req,
  output logic o_mem_wr,
  output logic o_mem_pm,
  output logic [13:0] o_mem_addr,
  output logic [23:0] o_mem_wdata,
  input wire logic [23:0] i_mem_rdata,
  input wire logic [15:0] i_host_ad,
  input wire logic i_host_port_select_n,
  input wire logic i_host_read_strobe_n,
  input wire logic i_host_write_strobe_n,
  input wire logic i_host_addr_latch,
  output logic [15:0] o_host_ad,
  output logic o_host_ad_oe_n,
  output logic o_host_ack_n,
  output logic o_dma_irq
);

  state_t st;
  state_t next_st;
  logic [19:0] host_sync;
  logic [15:0] h_ad;
  logic h_sel, h_rd, h_wr, h_lat, h_txn;
  logic core_ext, core_start, dma_start, bus_end, dma_byte_end, host_needs;
  logic [2:0] core_wait;

  // Host pins are asynchronous, so all of them pass the two-flop stage.
  sync_two_flop #(.WIDTH(20), .RESET_VALUE(HOST_SYNC_RESET)) u_host_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async({i_host_addr_latch, i_host_write_strobe_n, i_host_read_strobe_n,
              i_host_port_select_n, i_host_ad}),
    .o_sync(host_sync)
  );

  assign h_ad = host_sync[15:0];
  assign h_sel = ~host_sync[16];
  assign h_rd = ~host_sync[17];
  assign h_wr = ~host_sync[18];
  assign h_lat = host_sync[19];
  assign h_txn = h_sel & (h_rd | h_wr);

  assign core_ext = (i_core_space != SPACE_DM) ||
                    ((st.overlay != 2'h0) && (i_core_addr < DM_OVL_LIMIT));
  assign core_start = i_core_req & ~st.core_done & core_ext & ~st.bus_busy;
  // The core wins a free bus over byte DMA but waits out a busy one; byte DMA only fills idle slots.
  assign dma_start = (st.dma_state == DMA_BYTES) & ~st.bus_busy &
                     ~(i_core_req & core_ext & ~st.core_done);
  assign bus_end = st.bus_busy & (st.bus_wait == 3'h0);
  assign dma_byte_end = bus_end & st.bus_dma;
  assign host_needs = (st.host_state == HOST_ACCESS) &
                      (h_wr ? (st.host_dm | st.host_half) : (st.host_dm | ~st.host_half));

  always_comb begin
    case (i_core_space)
      SPACE_DM: core_wait = st.data_wait;
      SPACE_IO: core_wait = st.io_wait[i_core_addr[10:9]];
      default: core_wait = PM_WAIT;
    endcase
  end

  function automatic logic [1:0] bytes_per_word(input logic [1:0] fmt);
    case (fmt)
      FMT_PM24: bytes_per_word = 2'h3;
      FMT_DM16: bytes_per_word = 2'h2;
      default: bytes_per_word = 2'h1;
    endcase
  endfunction : bytes_per_word

  // Ends one word: advances the on-chip address and decrements the count.
  function automatic state_t finish_word(input state_t s);
    state_t r;
    r = s;
    r.onchip_addr = s.onchip_addr + 14'h1;
    r.count = s.count - 14'h1;
    r.byte_left = bytes_per_word(s.fmt);
    if (s.count == 14'h1) begin
      r.dma_state = DMA_IDLE;
      r.dma_irq = 1'b1;
      r.halt = 1'b0;
      r.ctx_pulse = s.ctx;
    end else begin
      r.dma_state = s.dir ? DMA_FETCH : DMA_BYTES;
    end
    finish_word = r;
  endfunction : finish_word

  always_comb begin
    next_st = st;
    next_st.pready = i_psel & ~i_penable;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0;
    next_st.core_done = 1'b0;
    next_st.dma_irq = 1'b0;
    next_st.ctx_pulse = 1'b0;
    next_st.mem_req = 1'b0;
    next_st.mem_wr = 1'b0;
    next_st.host_lat_d = h_lat;
    if (i_psel & ~i_penable) begin
      case (i_paddr)
        REG_CTRL: next_st.prdata = {28'h0, st.ctx, st.dir, st.fmt};
        REG_ONCHIP: next_st.prdata = {18'h0, st.onchip_addr};
        REG_EXT: next_st.prdata = {18'h0, st.ext_addr};
        REG_PAGE: next_st.prdata = {24'h0, st.page};
        REG_COUNT: next_st.prdata = {18'h0, st.count};
        REG_WAIT: next_st.prdata = {26'h0, st.byte_wait, st.data_wait};
        REG_IOWAIT: next_st.prdata = {20'h0, st.io_wait};
        REG_OVERLAY: next_st.prdata = {30'h0, st.overlay};
        REG_CMS: next_st.prdata = {28'h0, st.cms_en};
        REG_STATUS: next_st.prdata = {30'h0, st.host_state != HOST_IDLE,
                                      st.dma_state != DMA_IDLE};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (i_psel & i_penable & st.pready & i_pwrite) begin
      case (i_paddr)
        REG_CTRL: begin
          next_st.fmt = i_pwdata[CTRL_FMT_LSB +: 2];
          next_st.dir = i_pwdata[CTRL_DIR_BIT];
          next_st.ctx = i_pwdata[CTRL_CTX_BIT];
        end
        REG_ONCHIP: next_st.onchip_addr = i_pwdata[13:0];
        // Changing these mid-transfer corrupts the walk; software must wait.
        REG_EXT: next_st.ext_addr = i_pwdata[13:0];
        REG_PAGE: next_st.page = i_pwdata[7:0];
        REG_COUNT: begin
          next_st.count = i_pwdata[13:0];
          next_st.byte_left = bytes_per_word(st.fmt);
          if (i_pwdata[13:0] != 14'h0) begin
            next_st.dma_state = st.dir ? DMA_FETCH : DMA_BYTES;
            next_st.halt = st.ctx;
          end else begin
            next_st.dma_state = DMA_IDLE;
            next_st.halt = 1'b0;
          end
        end
        REG_WAIT: begin
          next_st.data_wait = i_pwdata[WAIT_DATA_LSB +: 3];
          next_st.byte_wait = i_pwdata[WAIT_BYTE_LSB +: 3];
        end
        REG_IOWAIT: next_st.io_wait = i_pwdata[11:0];
        REG_OVERLAY: next_st.overlay = i_pwdata[1:0];
        REG_CMS: next_st.cms_en = i_pwdata[3:0];
        default: ;
      endcase
    end

    // External bus: one access at a time, strobes held for wait count plus one.
    if (i_core_req & ~st.core_done & ~core_ext) begin
      next_st.core_done = 1'b1;
    end
    if (bus_end) begin
      next_st.bus_busy = 1'b0;
      next_st.sel = 4'h0;
      next_st.ext_rd = 1'b0;
      next_st.ext_wr = 1'b0;
      next_st.ext_oe_n = EXT_OE_N_RESET;
      if (!st.bus_dma) begin
        next_st.core_done = 1'b1;
        next_st.core_rdata = i_ext_data;
      end
    end else if (st.bus_busy) begin
      next_st.bus_wait = st.bus_wait - 3'h1;
    end else if (core_start) begin
      next_st.bus_busy = 1'b1;
      next_st.bus_dma = 1'b0;
      next_st.bus_wait = core_wait;
      next_st.ext_rd = ~i_core_wr;
      next_st.ext_wr = i_core_wr;
      next_st.ext_data = i_core_wdata;
      next_st.ext_oe_n = i_core_wr ? 3'h0 : EXT_OE_N_RESET;
      next_st.sel = 4'h0;
      case (i_core_space)
        SPACE_DM: begin
          next_st.sel[SEL_DM] = 1'b1;
          next_st.ext_addr_out = {st.overlay == 2'h2, i_core_addr[12:0]};
        end
        SPACE_IO: begin
          next_st.sel[SEL_IO] = 1'b1;
          next_st.ext_addr_out = {3'h0, i_core_addr[10:0]};
        end
        default: begin
          next_st.sel[SEL_PM] = 1'b1;
          next_st.ext_addr_out = i_core_addr;
        end
      endcase
    end else if (dma_start) begin
      next_st.bus_busy = 1'b1;
      next_st.bus_dma = 1'b1;
      next_st.bus_wait = st.byte_wait;
      next_st.ext_rd = ~st.dir;
      next_st.ext_wr = st.dir;
      next_st.sel = 4'h0;
      next_st.sel[SEL_BM] = 1'b1;
      next_st.ext_addr_out = st.ext_addr;
      next_st.ext_data = {st.page, st.word[23:16], 8'h00};
      next_st.ext_oe_n = {1'b0, ~st.dir, 1'b1};
    end
    next_st.composite_select_out = |(next_st.sel & next_st.cms_en);

    // Byte DMA engine; the internal end always goes to on-chip memory.
    case (st.dma_state)
      DMA_IDLE: ;
      DMA_FETCH: begin
        if (!host_needs) begin
          next_st.mem_req = 1'b1;
          next_st.mem_pm = st.fmt == FMT_PM24;
          next_st.mem_addr = st.onchip_addr;
          next_st.dma_state = DMA_ISSUED;
        end
      end
      DMA_ISSUED: next_st.dma_state = DMA_LOAD;
      DMA_LOAD: begin
        case (st.fmt)
          FMT_PM24: next_st.word = i_mem_rdata;
          FMT_DM16: next_st.word = {i_mem_rdata[15:0], 8'h00};
          FMT_DM8_HI: next_st.word = {i_mem_rdata[15:8], 16'h0};
          default: next_st.word = {i_mem_rdata[7:0], 16'h0};
        endcase
        next_st.dma_state = DMA_BYTES;
      end
      DMA_BYTES: begin
        if (dma_byte_end) begin
          {next_st.page, next_st.ext_addr} = {st.page, st.ext_addr} + 22'h1;
          next_st.byte_left = st.byte_left - 2'h1;
          next_st.word = st.dir ? {st.word[15:0], 8'h00} : {st.word[15:0], i_ext_data[15:8]};
          if (st.byte_left == 2'h1) begin
            if (st.dir) begin
              next_st = finish_word(next_st);
            end else begin
              next_st.dma_state = DMA_STORE;
            end
          end
        end
      end
      DMA_STORE: begin
        if (!host_needs) begin
          next_st.mem_req = 1'b1;
          next_st.mem_wr = 1'b1;
          next_st.mem_pm = st.fmt == FMT_PM24;
          next_st.mem_addr = st.onchip_addr;
          case (st.fmt)
            FMT_PM24: next_st.mem_wdata = st.word;
            FMT_DM16: next_st.mem_wdata = {8'h00, st.word[15:0]};
            FMT_DM8_HI: next_st.mem_wdata = {8'h00, st.word[7:0], 8'h00};
            default: next_st.mem_wdata = {16'h0, st.word[7:0]};
          endcase
          next_st = finish_word(next_st);
        end
      end
      default: next_st.dma_state = DMA_IDLE;
    endcase

    // Host port; program words move as upper 16 bits then the low byte.
    case (st.host_state)
      HOST_IDLE: begin
        if (st.host_lat_d & ~h_lat) begin
          next_st.host_addr = h_ad[13:0];
          next_st.host_dm = h_ad[HOST_DM_BIT];
          next_st.host_half = 1'b0;
        end else if (h_txn) begin
          next_st.host_state = HOST_ACCESS;
        end
      end
      HOST_ACCESS: begin
        next_st.host_state = HOST_END;
        next_st.mem_pm = host_needs ? ~st.host_dm : next_st.mem_pm;
        next_st.mem_addr = host_needs ? st.host_addr : next_st.mem_addr;
        if (h_wr) begin
          if (~st.host_dm & ~st.host_half) begin
            next_st.host_hold = h_ad;
            next_st.host_half = 1'b1;
          end else begin
            // Control registers at the top of data memory stay untouched.
            next_st.mem_req = ~(st.host_dm & (st.host_addr >= MMR_BASE));
            next_st.mem_wr = next_st.mem_req;
            next_st.mem_wdata = st.host_dm ? {8'h00, h_ad} : {st.host_hold, h_ad[7:0]};
            next_st.host_addr = st.host_addr + 14'h1;
            next_st.host_half = 1'b0;
          end
        end else if (~st.host_dm & st.host_half) begin
          next_st.host_out = {8'h00, st.host_hold[7:0]};
          next_st.host_addr = st.host_addr + 14'h1;
          next_st.host_half = 1'b0;
        end else begin
          next_st.mem_req = 1'b1;
          next_st.host_state = HOST_ISSUED;
        end
      end
      HOST_ISSUED: next_st.host_state = HOST_CAPTURE;
      HOST_CAPTURE: begin
        next_st.host_state = HOST_END;
        if (st.host_dm) begin
          next_st.host_out = i_mem_rdata[15:0];
          next_st.host_addr = st.host_addr + 14'h1;
        end else begin
          next_st.host_out = i_mem_rdata[23:8];
          next_st.host_hold = {8'h00, i_mem_rdata[7:0]};
          next_st.host_half = 1'b1;
        end
      end
      HOST_END: begin
        if (!h_txn) begin
          next_st.host_state = HOST_IDLE;
        end
      end
      default: next_st.host_state = HOST_IDLE;
    endcase
    next_st.host_ack_n = ~((next_st.host_state == HOST_IDLE) ||
                           (next_st.host_state == HOST_END));
    next_st.host_oe_n = ~((next_st.host_state == HOST_END) & h_rd & h_sel);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st <= '0;
      st.cms_en <= CMS_EN_RESET;
      st.ext_oe_n <= EXT_OE_N_RESET;
      st.host_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_prdata = st.prdata;
  assign o_core_done = st.core_done;
  assign o_core_rdata = st.core_rdata;
  assign o_core_halt = st.halt;
  assign o_core_ctx_reset = st.ctx_pulse;
  assign o_ext_addr = st.ext_addr_out;
  assign o_ext_data = st.ext_data;
  assign o_ext_data_oe_n = st.ext_oe_n;
  assign o_program_mem_select = st.sel[SEL_PM];
  assign o_data_mem_select = st.sel[SEL_DM];
  assign o_byte_mem_select = st.sel[SEL_BM];
  assign o_io_space_select = st.sel[SEL_IO];
  assign o_composite_select_out = st.composite_select_out;
  assign o_ext_rd = st.ext_rd;
  assign o_ext_wr = st.ext_wr;
  assign o_mem_req = st.mem_req;
  assign o_mem_wr = st.mem_wr;
  assign o_mem_pm = st.mem_pm;
  assign o_mem_addr = st.mem_addr;
  assign o_mem_wdata = st.mem_wdata;
  assign o_host_ad = st.host_out;
  assign o_host_ad_oe_n = st.host_oe_n;
  assign o_host_ack_n = st.host_ack_n;
  assign o_dma_irq = st.dma_irq;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_internal_one_cycle: assert property (
    (i_core_req & ~st.core_done & (i_core_space == SPACE_DM) & (st.overlay == 2'h0))
      |=> o_core_done & ~o_data_mem_select)
    else $error("internal data access did not finish in one cycle");
  a_overlay_bit13: assert property (
    $rose(o_data_mem_select) |-> o_ext_addr[13] == ($past(st.overlay) == 2'h2))
    else $error("overlay address bit 13 wrong");
  a_data_wait_len: assert property (
    $rose(o_data_mem_select) |-> st.bus_wait == st.data_wait)
    else $error("data access wait count wrong");
  a_io_region_wait: assert property (
    $rose(o_io_space_select) |-> st.bus_wait == st.io_wait[o_ext_addr[10:9]]
      && o_ext_addr[13:11] == 3'h0)
    else $error("I/O wait or address wrong");
  a_cms_combine: assert property (
    o_composite_select_out == |({o_io_space_select, o_byte_mem_select,
      o_data_mem_select, o_program_mem_select} & st.cms_en))
    else $error("composite select mismatch");
  a_cms_reset: assert property (
    $fell(i_sys_rst) |-> st.cms_en == CMS_EN_RESET)
    else $error("composite enables not at reset value");
  a_byte_page_out: assert property (
    o_byte_mem_select |-> o_ext_data[23:16] == st.page && ~o_ext_data_oe_n[2])
    else $error("page not on upper data lane");
  a_page_carry: assert property (
    (dma_byte_end && st.ext_addr == 14'h3FFF)
      |=> st.ext_addr == 14'h0 && st.page == $past(st.page) + 8'h1)
    else $error("byte address did not carry into page");
  a_core_wins: assert property (
    (i_core_req & core_ext & ~st.core_done & ~st.bus_busy) |=> ~st.bus_dma)
    else $error("byte DMA took bus from core");
  a_irq_at_zero: assert property (
    o_dma_irq |-> st.count == 14'h0 && st.dma_state == DMA_IDLE ##1 ~o_dma_irq)
    else $error("completion pulse at wrong time");
  a_no_mmr_write: assert property (
    (o_mem_req & o_mem_wr & ~o_mem_pm & $past(host_needs))
      |-> o_mem_addr < MMR_BASE)
    else $error("host wrote a control register");

  c_dma_done: cover property (o_dma_irq);
  c_host_write: cover property ((st.host_state == HOST_ACCESS) && h_wr ##1 o_mem_req);
  c_io_access: cover property ($rose(o_io_space_select));

endmodule : memory_interface_dma

`default_nettype wire

// file: mem_dma_pkg.sv
package mem_dma_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ONCHIP = 8'h04;
  localparam logic [7:0] REG_EXT = 8'h08;
  localparam logic [7:0] REG_PAGE = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_WAIT = 8'h14;
  localparam logic [7:0] REG_IOWAIT = 8'h18;
  localparam logic [7:0] REG_OVERLAY = 8'h1C;
  localparam logic [7:0] REG_CMS = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;

  // Field positions.
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_CTX_BIT = 3;
  localparam int WAIT_DATA_LSB = 0;
  localparam int WAIT_BYTE_LSB = 3;
  localparam int SEL_PM = 0;
  localparam int SEL_DM = 1;
  localparam int SEL_BM = 2;
  localparam int SEL_IO = 3;
  localparam int HOST_DM_BIT = 14;

  // Reset values that are not zero.
  localparam logic [3:0] CMS_EN_RESET = 4'hB;
  localparam logic [2:0] EXT_OE_N_RESET = 3'h7;
  localparam logic [19:0] HOST_SYNC_RESET = 20'h70000;

  // Address limits and fixed wait count.
  localparam logic [13:0] DM_OVL_LIMIT = 14'h2000;
  localparam logic [13:0] MMR_BASE = 14'h3FE0;
  localparam logic [2:0] PM_WAIT = 3'h0;

  // Core access spaces and byte transfer formats.
  localparam logic [1:0] SPACE_DM = 2'h0;
  localparam logic [1:0] SPACE_IO = 2'h1;
  localparam logic [1:0] SPACE_PM = 2'h2;
  localparam logic [1:0] FMT_PM24 = 2'h0;
  localparam logic [1:0] FMT_DM16 = 2'h1;
  localparam logic [1:0] FMT_DM8_HI = 2'h2;

  typedef enum logic [2:0] {
    DMA_IDLE, DMA_FETCH, DMA_ISSUED, DMA_LOAD, DMA_BYTES, DMA_STORE
  } dma_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE, HOST_ACCESS, HOST_ISSUED, HOST_CAPTURE, HOST_END
  } host_state_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] fmt;
    logic dir;
    logic ctx;
    logic [13:0] onchip_addr;
    logic [13:0] ext_addr;
    logic [7:0] page;
    logic [13:0] count;
    logic [2:0] data_wait;
    logic [2:0] byte_wait;
    logic [3:0][2:0] io_wait;
    logic [1:0] overlay;
    logic [3:0] cms_en;
    logic bus_busy;
    logic bus_dma;
    logic [2:0] bus_wait;
    logic [13:0] ext_addr_out;
    logic [23:0] ext_data;
    logic [2:0] ext_oe_n;
    logic [3:0] sel;
    logic composite_select_out;
    logic ext_rd;
    logic ext_wr;
    logic core_done;
    logic [23:0] core_rdata;
    dma_state_t dma_state;
    logic [23:0] word;
    logic [1:0] byte_left;
    logic dma_irq;
    logic ctx_pulse;
    logic halt;
    logic mem_req;
    logic mem_wr;
    logic mem_pm;
    logic [13:0] mem_addr;
    logic [23:0] mem_wdata;
    host_state_t host_state;
    logic [13:0] host_addr;
    logic host_dm;
    logic host_half;
    logic [15:0] host_hold;
    logic [15:0] host_out;
    logic host_oe_n;
    logic host_ack_n;
    logic host_lat_d;
  } state_t;

endpackage : mem_dma_pkg

// file: sync_two_flop.sv
`timescale 1ns/10ps
`default_nettype none

module sync_two_flop #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.first = i_async;
    next_st.second = st.first;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.second;

endmodule : sync_two_flop

`default_nettype wire

// file: byte_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module byte_mem_model (
  input wire logic i_clock,
  input wire logic i_sel,
  input wire logic [13:0] i_addr,
  input wire logic [23:0] i_drv,
  output logic [23:0] o_data
);
  logic [23:0] word;
  logic [23:0] last = 24'h0;

  // Page and offset are mixed into the byte, so a lost carry shows in the data.
  assign word = {8'h00, i_addr[7:0] ^ i_drv[23:16], i_addr[7:0]};
  // A released bus shows the inverse of the last value, never a kind zero.
  assign o_data = i_sel ? word : ~last;

  always @(posedge i_clock) begin
    if (i_sel) begin
      last <= word;
    end
  end
endmodule : byte_mem_model

`default_nettype wire

// file: memory_interface_dma_test.sv
`timescale 1ns/10ps
`default_nettype none

module memory_interface_dma_test import mem_dma_pkg::*; ();
  logic i_clock = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, i_core_req = 1'h0;
  logic i_core_wr = 1'h0, er, o_pready, o_pslverr, o_core_done, o_data_mem_select;
  logic o_byte_mem_select, o_composite_select_out, o_mem_req, o_mem_wr, o_dma_irq;
  logic o_core_halt, o_core_ctx_reset, o_ext_wr, o_host_ack_n, i_host_addr_latch = 1'h0;
  logic i_host_port_select_n = 1'h1, i_host_write_strobe_n = 1'h1;
  logic [15:0] bw, i_host_ad = 16'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd, o_prdata;
  logic [1:0] i_core_space = 2'h0;
  logic [13:0] i_core_addr = 14'h0, ea, ma, o_ext_addr, o_mem_addr;
  logic [23:0] i_core_wdata = 24'h0, i_ext_data, o_ext_data, o_core_rdata;
  logic [23:0] o_mem_wdata, i_mem_rdata, wd;
  int err_total = 0, num_checks = 0, data_mem_select = 0, composite_select_out = 0, byte_mem_select = 0, mems = 0, irqs = 0;
  int hb = 0, cx = 0;

  assign i_mem_rdata = {10'h0, o_mem_addr};

  memory_interface_dma u_dut (
    .i_clock, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_pready, .o_pslverr, .o_prdata, .i_core_req, .i_core_wr, .i_core_space,
    .i_core_addr, .i_core_wdata, .o_core_done, .o_core_rdata, .o_core_halt,
    .o_core_ctx_reset, .o_ext_addr, .i_ext_data, .o_ext_data, .o_ext_data_oe_n(),
    .o_program_mem_select(), .o_data_mem_select, .o_byte_mem_select,
    .o_io_space_select(), .o_composite_select_out, .o_ext_rd(), .o_ext_wr,
    .o_mem_req, .o_mem_wr, .o_mem_pm(), .o_mem_addr, .o_mem_wdata, .i_mem_rdata,
    .i_host_ad, .i_host_port_select_n, .i_host_read_strobe_n(1'h1),
    .i_host_write_strobe_n, .i_host_addr_latch, .o_host_ad(),
    .o_host_ad_oe_n(), .o_host_ack_n, .o_dma_irq
  );

  byte_mem_model u_mem (
    .i_clock, .i_sel(o_byte_mem_select | o_data_mem_select),
    .i_addr(o_ext_addr), .i_drv(o_ext_data), .o_data(i_ext_data)
  );

  initial begin
    forever #4 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (o_data_mem_select) begin
      data_mem_select <= data_mem_select + 1;
      ea <= o_ext_addr;
    end
    composite_select_out <= composite_select_out + int'(o_composite_select_out);
    byte_mem_select <= byte_mem_select + int'(o_byte_mem_select);
    mems <= mems + int'(o_mem_req & o_mem_wr);
    irqs <= irqs + int'(o_dma_irq);
    if (o_mem_req & o_mem_wr) begin
      wd <= o_mem_wdata;
      ma <= o_mem_addr;
    end
    if (o_byte_mem_select & o_ext_wr) begin
      bw <= {bw[7:0], o_ext_data[15:8]};
    end
    hb <= hb + int'(o_byte_mem_select & o_core_halt);
    cx <= cx + int'(o_core_ctx_reset);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // The leading edge keeps a new setup from landing in the step of the last release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'h1;
    @(posedge i_clock);
    while (o_pready !== 1'h1) @(posedge i_clock);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask : apb

  task automatic core(input logic [1:0] s, input logic [13:0] a);
    i_core_req <= 1'h1;
    i_core_space <= s;
    i_core_addr <= a;
    @(posedge i_clock);
    while (o_core_done !== 1'h1) @(posedge i_clock);
    i_core_req <= 1'h0;
  endtask : core

  // A latch call sends an address word; otherwise one data write, held until acknowledged.
  task automatic host(input logic l, input logic [15:0] v);
    i_host_ad <= v;
    if (l) begin
      i_host_addr_latch <= 1'h1;
      repeat (3) @(posedge i_clock);
      i_host_addr_latch <= 1'h0;
    end else begin
      i_host_port_select_n <= 1'h0;
      i_host_write_strobe_n <= 1'h0;
      while (o_host_ack_n !== 1'h1) @(posedge i_clock);
      while (o_host_ack_n !== 1'h0) @(posedge i_clock);
      i_host_port_select_n <= 1'h1;
      i_host_write_strobe_n <= 1'h1;
    end
    repeat (3) @(posedge i_clock);
  endtask : host

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'h0;
    apb(1'h0, REG_CMS, 32'h0);
    chk(rd, 32'hB);
    apb(1'h1, 8'hF0, 32'h1);
    chk({31'h0, er}, 32'h1);
    apb(1'h1, REG_WAIT, 32'h2);
    apb(1'h1, REG_OVERLAY, 32'h2);
    core(SPACE_DM, 14'h0123);
    chk(ea, 14'h2123);
    chk(data_mem_select, 3);
    chk(composite_select_out, 3);
    chk(o_core_rdata[7:0], 8'h23);
    apb(1'h1, REG_IOWAIT, 32'h140);
    core(SPACE_IO, 14'h0456);
    chk(composite_select_out, 9);
    apb(1'h1, REG_OVERLAY, 32'h0);
    core(SPACE_DM, 14'h0123);
    chk(data_mem_select, 3);
    apb(1'h1, REG_CTRL, 32'h3);
    apb(1'h1, REG_EXT, 32'h3FFF);
    apb(1'h1, REG_PAGE, 32'h5);
    apb(1'h1, REG_COUNT, 32'h2);
    while (irqs == 0) @(posedge i_clock);
    chk(wd, 24'h6);
    chk(mems, 2);
    apb(1'h0, REG_COUNT, 32'h0);
    chk(rd, 32'h0);
    repeat (20) @(posedge i_clock);
    chk(byte_mem_select, 2);
    chk(irqs, 1);
    apb(1'h1, REG_ONCHIP, 32'h155);
    apb(1'h1, REG_CTRL, 32'hD);
    apb(1'h1, REG_COUNT, 32'h1);
    while (irqs == 1) @(posedge i_clock);
    chk(bw, 16'h0155);
    chk(hb, 2);
    chk(cx, 1);
    apb(1'h0, REG_PAGE, 32'h0);
    chk(rd, 32'h6);
    host(1'h1, 16'h4010);
    host(1'h0, 16'hBEEF);
    host(1'h0, 16'h1234);
    chk(wd, 24'h1234);
    chk(ma, 14'h11);
    host(1'h1, 16'h7FE0);
    host(1'h0, 16'h5555);
    chk(mems, 4);
    report_and_stop();
  end
endmodule : memory_interface_dma_test

`default_nettype wire
